// ===== design/mode_reg_pkg.sv
// Package with the constants and carrier types of the extended mode register block.
package mode_reg_pkg;

  // ------------------------------------------------------------------
  // Register and address layout
  // ------------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int BANK_W = 3;
  localparam logic [BANK_W-1:0] BANK_BASE_MODE = 3'h0;
  localparam logic [BANK_W-1:0] BANK_EXT_MODE = 3'h1;
  localparam logic [BANK_W-1:0] BANK_WRITE_MODE = 3'h2;
  localparam logic [ADDR_W-1:0] EXT_MODE_RESET = 17'h00000;

  // Bit positions inside the extended mode configuration word.
  localparam int POS_DLL_OFF = 0;
  localparam int POS_DRV_LO = 1;
  localparam int POS_RTT_LO = 2;
  localparam int POS_AL_LO = 3;
  localparam int POS_AL_HI = 4;
  localparam int POS_DRV_HI = 5;
  localparam int POS_RTT_MID = 6;
  localparam int POS_WLVL = 7;
  localparam int POS_RTT_HI = 9;
  localparam int POS_TDQS = 11;
  localparam int POS_QOFF = 12;
  localparam logic [ADDR_W-1:0] EXT_RESERVED_MASK = 17'h12500;

  // Bit positions inside the base and write mode words.
  localparam int POS_BASE_DLL_RESET = 8;
  localparam int POS_CL_LO = 4;
  localparam int POS_CL_HI = 6;
  localparam int POS_CWL_LO = 3;
  localparam int POS_CWL_HI = 5;
  localparam logic [3:0] CL_OFFSET = 4'h4;
  localparam logic [3:0] CWL_OFFSET = 4'h5;
  localparam logic [3:0] CL_RESET = 4'h5;
  localparam logic [3:0] CWL_RESET = 4'h5;

  // ------------------------------------------------------------------
  // Field encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CL_M1 = 2'h1;
  localparam logic [1:0] AL_CL_M2 = 2'h2;
  localparam int AL_PIPE = 16;

  // Termination and drive are reported as divisors of the reference resistance.
  localparam logic [3:0] DIV_OFF = 4'h0;
  localparam logic [3:0] DIV_2 = 4'h2;
  localparam logic [3:0] DIV_4 = 4'h4;
  localparam logic [3:0] DIV_6 = 4'h6;
  localparam logic [3:0] DIV_7 = 4'h7;
  localparam logic [3:0] DIV_8 = 4'h8;
  localparam logic [3:0] DIV_12 = 4'hC;

  localparam int SYNC_BITS = 6;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_pins_t;

  localparam cmd_pins_t CMD_MODE_SET = 4'h0;
  localparam cmd_pins_t CMD_READ = 4'h5;
  localparam cmd_pins_t CMD_WRITE = 4'h4;

  typedef struct packed {
    logic qoff;
    logic tdqs;
    logic [2:0] rtt_sel;
    logic wlvl;
    logic [1:0] al_sel;
    logic [1:0] drv_sel;
    logic dll_off;
  } ext_fields_t;

  localparam ext_fields_t EXT_FIELDS_RESET = 11'h000;

endpackage

// ===== design/level_sync.sv
// Two flip-flop synchroniser for one level.
`timescale 1ns/1ps
module level_sync (
  input wire logic clk, // Destination clock.
  input wire logic din, // Level from another domain.
  output logic dout // Synchronised level.
);

  logic meta_q;
  logic hold_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    meta_q <= din;
    hold_q <= meta_q;
  end

  assign dout = hold_q;

endmodule

// ===== design/dram_mode_register_one.sv
// Extended mode register of a DRAM: command capture on the memory clock, effects on core_clk.
`timescale 1ns/1ps
//
// Behaviour
// - Register keeps its value until rewritten or reset; array untouched.
// - Bit 0 of the loaded word enables or disables the DLL.
// - Self refresh turns DLL off; exit re-enables and resets if it was on.
// - Bits 5 and 1 select output drive impedance; divisor six is the default after reset and for 00.
// - Bit 12 set holds data and strobe outputs in high impedance.
// - Bit 11 on by-8 parts terminates TDQS and drops data mask.
// - Bits 9, 6, 2 choose nominal termination divisor 2, 4, 6, 8 or 12.
// - Writes with dynamic termination use write value, then restore nominal.
// - Once enabled, termination follows the ODT pin.
// - Bit 7 set enters write leveling.
// - In leveling, bit 12 set offers all values, else write values only.
// - Bits 4 and 3 select additive latency zero, CL minus one, minus two.
// - Commands held for additive latency; RL is AL plus CL, WL AL plus CWL.
// - Base register bit 8 starts DLL reset and clears itself.
module dram_mode_register_one (
  input wire logic core_clk, // Core clock, 100 MHz.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic mem_ck, // Memory command clock from the controller.
  input wire mode_reg_pkg::cmd_pins_t cmd_pins, // Command pins, sampled on mem_ck.
  input wire logic [mode_reg_pkg::BANK_W-1:0] bank_addr, // Bank address pins.
  input wire logic [mode_reg_pkg::ADDR_W-1:0] addr, // Address pins.
  input wire logic odt_pin, // Termination control pin, asynchronous.
  input wire logic self_refresh, // Self refresh active, core logic level.
  input wire logic rd_burst, // Read burst in progress, core logic level.
  input wire logic wr_burst, // Write burst in progress, core logic level.
  input wire logic [3:0] rtt_wr_div, // Dynamic write termination divisor, 0 off.
  output logic [mode_reg_pkg::ADDR_W-1:0] ext_mode_q, // Copy of the register.
  output logic dll_on_q, // DLL running.
  output logic dll_reset_q, // One-cycle DLL reset pulse.
  output logic [3:0] drive_div_q, // Output driver divisor, 0 reserved.
  output logic [3:0] rtt_div_q, // Applied termination divisor, 0 off.
  output logic out_enable_q, // Data and strobe outputs may drive.
  output logic dm_enable_q, // Data mask function active.
  output logic tdqs_term_q, // Termination applied on TDQS pair.
  output logic write_level_q, // Write leveling mode.
  output logic [3:0] add_lat_q, // Additive latency in memory clocks.
  output logic [4:0] read_lat_q, // Read latency in memory clocks.
  output logic [4:0] write_lat_q, // Write latency in memory clocks.
  output logic rd_release_q, // One-cycle pulse: read released internally.
  output logic wr_release_q // One-cycle pulse: write released internally.
);

  // ------------------------------------------------------------------
  // Reset into the memory clock domain
  // ------------------------------------------------------------------
  logic ck_rst_n;

  level_sync u_rst_sync (
    .clk(mem_ck),
    .din(reset_n),
    .dout(ck_rst_n)
  );

  // ------------------------------------------------------------------
  // Command capture on mem_ck
  // ------------------------------------------------------------------
  logic [mode_reg_pkg::ADDR_W-1:0] ck_ext_q;
  logic [3:0] ck_cl_q;
  logic [3:0] ck_cwl_q;
  logic ck_dll_rst_bit_q;
  logic ck_ext_tgl_q;
  logic ck_dll_tgl_q;
  logic ck_lat_tgl_q;
  logic mode_set;
  logic is_read;
  logic is_write;

  assign mode_set = (cmd_pins == mode_reg_pkg::CMD_MODE_SET);
  assign is_read = (cmd_pins == mode_reg_pkg::CMD_READ);
  assign is_write = (cmd_pins == mode_reg_pkg::CMD_WRITE);

  // The word is taken in the single clock of the mode set command.
  always_ff @(posedge mem_ck) begin
    if (!ck_rst_n) begin
      ck_ext_q <= mode_reg_pkg::EXT_MODE_RESET;
      ck_ext_tgl_q <= 1'b0;
    end else if (mode_set && bank_addr == mode_reg_pkg::BANK_EXT_MODE) begin
      ck_ext_q <= addr;
      ck_ext_tgl_q <= ~ck_ext_tgl_q;
    end
  end

  always_ff @(posedge mem_ck) begin
    if (!ck_rst_n) begin
      ck_cl_q <= mode_reg_pkg::CL_RESET;
      ck_cwl_q <= mode_reg_pkg::CWL_RESET;
      ck_lat_tgl_q <= 1'b0;
    end else if (mode_set && bank_addr == mode_reg_pkg::BANK_BASE_MODE) begin
      ck_cl_q <= {1'b0, addr[mode_reg_pkg::POS_CL_HI:mode_reg_pkg::POS_CL_LO]}
        + mode_reg_pkg::CL_OFFSET;
      ck_lat_tgl_q <= ~ck_lat_tgl_q;
    end else if (mode_set && bank_addr == mode_reg_pkg::BANK_WRITE_MODE) begin
      ck_cwl_q <= {1'b0, addr[mode_reg_pkg::POS_CWL_HI:mode_reg_pkg::POS_CWL_LO]}
        + mode_reg_pkg::CWL_OFFSET;
      ck_lat_tgl_q <= ~ck_lat_tgl_q;
    end
  end

  // The DLL reset bit is set by the write and drops back on the next clock.
  always_ff @(posedge mem_ck) begin
    if (!ck_rst_n) begin
      ck_dll_rst_bit_q <= 1'b0;
      ck_dll_tgl_q <= 1'b0;
    end else begin
      ck_dll_rst_bit_q <= mode_set && bank_addr == mode_reg_pkg::BANK_BASE_MODE
                          && addr[mode_reg_pkg::POS_BASE_DLL_RESET];
      ck_dll_tgl_q <= ck_dll_tgl_q ^ ck_dll_rst_bit_q;
    end
  end

  // ------------------------------------------------------------------
  // Additive latency on mem_ck
  // ------------------------------------------------------------------
  logic [3:0] ck_al;
  logic [mode_reg_pkg::AL_PIPE-1:0] rd_pipe_q;
  logic [mode_reg_pkg::AL_PIPE-1:0] wr_pipe_q;
  logic ck_rd_rel;
  logic ck_wr_rel;
  logic ck_rd_tgl_q;
  logic ck_wr_tgl_q;

  always_comb begin
    unique case (ck_ext_q[mode_reg_pkg::POS_AL_HI:mode_reg_pkg::POS_AL_LO])
      mode_reg_pkg::AL_CL_M1: ck_al = ck_cl_q - 4'h1;
      mode_reg_pkg::AL_CL_M2: ck_al = ck_cl_q - 4'h2;
      default: ck_al = 4'h0;
    endcase
  end

  always_ff @(posedge mem_ck) begin
    if (!ck_rst_n) begin
      rd_pipe_q <= '0;
      wr_pipe_q <= '0;
    end else begin
      rd_pipe_q <= {rd_pipe_q[mode_reg_pkg::AL_PIPE-2:0], is_read};
      wr_pipe_q <= {wr_pipe_q[mode_reg_pkg::AL_PIPE-2:0], is_write};
    end
  end

  // A command is held for the additive latency before it is released.
  assign ck_rd_rel = (ck_al == 4'h0) ? is_read : rd_pipe_q[ck_al - 4'h1];
  assign ck_wr_rel = (ck_al == 4'h0) ? is_write : wr_pipe_q[ck_al - 4'h1];

  always_ff @(posedge mem_ck) begin
    if (!ck_rst_n) begin
      ck_rd_tgl_q <= 1'b0;
      ck_wr_tgl_q <= 1'b0;
    end else begin
      ck_rd_tgl_q <= ck_rd_tgl_q ^ ck_rd_rel;
      ck_wr_tgl_q <= ck_wr_tgl_q ^ ck_wr_rel;
    end
  end

  // ------------------------------------------------------------------
  // Crossing into core_clk
  // ------------------------------------------------------------------
  logic [mode_reg_pkg::SYNC_BITS-1:0] sync_in;
  logic [mode_reg_pkg::SYNC_BITS-1:0] sync_out;
  logic [mode_reg_pkg::SYNC_BITS-1:0] sync_last_q;
  logic [mode_reg_pkg::SYNC_BITS-1:0] sync_edge;

  assign sync_in = {odt_pin, ck_wr_tgl_q, ck_rd_tgl_q, ck_dll_tgl_q, ck_ext_tgl_q, ck_lat_tgl_q};

  generate
    for (genvar i = 0; i < mode_reg_pkg::SYNC_BITS; i++) begin : g_sync
      level_sync u_sync (
        .clk(core_clk),
        .din(sync_in[i]),
        .dout(sync_out[i])
      );
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sync_last_q <= '0;
    end else begin
      sync_last_q <= sync_out;
    end
  end

  assign sync_edge = sync_out ^ sync_last_q;

  // ------------------------------------------------------------------
  // Register copy and field decode on core_clk
  // ------------------------------------------------------------------
  mode_reg_pkg::ext_fields_t f;
  logic sr_last_q;

  // Mode set spacing keeps the memory-side word steady while the toggle crosses.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ext_mode_q <= mode_reg_pkg::EXT_MODE_RESET;
    end else if (sync_edge[1]) begin
      ext_mode_q <= ck_ext_q;
    end
  end

  assign f = {ext_mode_q[mode_reg_pkg::POS_QOFF], ext_mode_q[mode_reg_pkg::POS_TDQS],
              ext_mode_q[mode_reg_pkg::POS_RTT_HI], ext_mode_q[mode_reg_pkg::POS_RTT_MID],
              ext_mode_q[mode_reg_pkg::POS_RTT_LO], ext_mode_q[mode_reg_pkg::POS_WLVL],
              ext_mode_q[mode_reg_pkg::POS_AL_HI], ext_mode_q[mode_reg_pkg::POS_AL_LO],
              ext_mode_q[mode_reg_pkg::POS_DRV_HI], ext_mode_q[mode_reg_pkg::POS_DRV_LO],
              ext_mode_q[mode_reg_pkg::POS_DLL_OFF]};

  // ------------------------------------------------------------------
  // Latency words on core_clk
  // ------------------------------------------------------------------
  logic [3:0] cl_q;
  logic [3:0] cwl_q;
  logic [3:0] core_al;

  // Mode set spacing keeps the memory-side latencies steady while the toggle crosses.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cl_q <= mode_reg_pkg::CL_RESET;
      cwl_q <= mode_reg_pkg::CWL_RESET;
    end else if (sync_edge[0]) begin
      cl_q <= ck_cl_q;
      cwl_q <= ck_cwl_q;
    end
  end

  always_comb begin
    unique case (f.al_sel)
      mode_reg_pkg::AL_CL_M1: core_al = cl_q - 4'h1;
      mode_reg_pkg::AL_CL_M2: core_al = cl_q - 4'h2;
      default: core_al = 4'h0;
    endcase
  end

  // ------------------------------------------------------------------
  // DLL control
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sr_last_q <= 1'b0;
      dll_on_q <= 1'b0;
      dll_reset_q <= 1'b0;
    end else begin
      sr_last_q <= self_refresh;
      dll_on_q <= !f.dll_off && !self_refresh;
      dll_reset_q <= sync_edge[2] || (sr_last_q && !self_refresh && !f.dll_off);
    end
  end

  // ------------------------------------------------------------------
  // Drivers, mask and strobe termination
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      drive_div_q <= mode_reg_pkg::DIV_6;
      out_enable_q <= 1'b1;
      dm_enable_q <= 1'b1;
      tdqs_term_q <= 1'b0;
      write_level_q <= 1'b0;
    end else begin
      unique case (f.drv_sel)
        2'h0: drive_div_q <= mode_reg_pkg::DIV_6;
        2'h1: drive_div_q <= mode_reg_pkg::DIV_7;
        default: drive_div_q <= mode_reg_pkg::DIV_OFF;
      endcase
      out_enable_q <= !f.qoff;
      dm_enable_q <= !f.tdqs;
      tdqs_term_q <= f.tdqs && (rtt_div_q != mode_reg_pkg::DIV_OFF);
      write_level_q <= f.wlvl;
    end
  end

  // ------------------------------------------------------------------
  // Termination
  // ------------------------------------------------------------------
  logic [3:0] nom_div;
  logic nom_write_ok;
  logic [3:0] rtt_d;

  always_comb begin
    nom_write_ok = 1'b1;
    unique case (f.rtt_sel)
      3'h1: nom_div = mode_reg_pkg::DIV_4;
      3'h2: nom_div = mode_reg_pkg::DIV_2;
      3'h3: nom_div = mode_reg_pkg::DIV_6;
      3'h4: begin
        nom_div = mode_reg_pkg::DIV_12;
        nom_write_ok = 1'b0;
      end
      3'h5: begin
        nom_div = mode_reg_pkg::DIV_8;
        nom_write_ok = 1'b0;
      end
      default: nom_div = mode_reg_pkg::DIV_OFF;
    endcase
  end

  always_comb begin
    rtt_d = nom_div;
    if (f.wlvl && !f.qoff && !nom_write_ok) begin
      rtt_d = mode_reg_pkg::DIV_OFF;
    end else if (wr_burst && rtt_wr_div != mode_reg_pkg::DIV_OFF && !f.wlvl) begin
      rtt_d = rtt_wr_div;
    end
    if (!sync_out[5] || rd_burst || !dll_on_q) begin
      rtt_d = mode_reg_pkg::DIV_OFF;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rtt_div_q <= mode_reg_pkg::DIV_OFF;
    end else begin
      rtt_div_q <= rtt_d;
    end
  end

  // ------------------------------------------------------------------
  // Latencies and released commands
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      add_lat_q <= 4'h0;
      read_lat_q <= 5'h00;
      write_lat_q <= 5'h00;
      rd_release_q <= 1'b0;
      wr_release_q <= 1'b0;
    end else begin
      add_lat_q <= core_al;
      read_lat_q <= {1'b0, core_al} + {1'b0, cl_q};
      write_lat_q <= {1'b0, core_al} + {1'b0, cwl_q};
      rd_release_q <= sync_edge[3];
      wr_release_q <= sync_edge[4];
    end
  end

endmodule

// ===== bench/mode_reg_chk.sv
// Checker of the extended mode register outputs against their causes.
`timescale 1ns/1ps
module mode_reg_chk (
  input wire logic core_clk, // Clock.
  input wire logic reset_n, // Reset.
  input wire logic odt_pin, // Termination pin.
  input wire logic self_refresh, // Self refresh.
  input wire logic rd_burst, // Read burst.
  input wire logic wr_burst, // Write burst.
  input wire logic [3:0] rtt_wr_div, // Write termination.
  input wire logic [16:0] ext_mode_q, // Register copy.
  input wire logic dll_on_q, // DLL running.
  input wire logic dll_reset_q, // DLL reset pulse.
  input wire logic [3:0] drive_div_q, // Drive divisor.
  input wire logic [3:0] rtt_div_q, // Termination divisor.
  input wire logic out_enable_q, // Output enable.
  input wire logic tdqs_term_q, // Strobe termination.
  input wire logic write_level_q, // Leveling.
  input wire logic [3:0] add_lat_q // Additive latency.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [16:0] prev_q;
  logic prev_ok_q;
  logic [1:0] odt_cnt_q;
  always_ff @(posedge core_clk) begin
    prev_q <= ext_mode_q;
    prev_ok_q <= reset_n;
  end
  // ----------------------------------------------------------------
  // Counts settled cycles of the termination pin past its synchroniser.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n || !odt_pin) odt_cnt_q <= 2'h0;
    else if (odt_cnt_q != 2'h3) odt_cnt_q <= odt_cnt_q + 2'h1;
  end
  sequence dyn_cause;
    odt_cnt_q == 2'h3 && odt_pin && wr_burst && !rd_burst && rtt_wr_div != 4'h0 &&
      dll_on_q && !write_level_q && !ext_mode_q[7];
  endsequence
  sequence off_cause;
    rd_burst || !dll_on_q;
  endsequence
  a_reset_state: assert property ($rose(reset_n) |-> ext_mode_q == 17'h00000 &&
    drive_div_q == 4'h6 && out_enable_q && !dll_on_q && rtt_div_q == 4'h0)
    else $error("state after reset wrong");
  a_qoff_decode: assert property (prev_ok_q |-> out_enable_q == !prev_q[12])
    else $error("output enable wrong");
  a_dll_decode: assert property (prev_ok_q |->
    dll_on_q == (!prev_q[0] && !$past(self_refresh))) else $error("dll state wrong");
  a_drive_decode: assert property (prev_ok_q |->
    drive_div_q == (prev_q[5] ? 4'h0 : (prev_q[1] ? 4'h7 : 4'h6))) else $error("drive wrong");
  a_al_zero: assert property (prev_ok_q && prev_q[4] == prev_q[3] |-> add_lat_q == 4'h0)
    else $error("additive latency not zero");
  a_level_decode: assert property (prev_ok_q |-> write_level_q == prev_q[7])
    else $error("leveling wrong");
  a_tdqs_term: assert property (prev_ok_q |->
    tdqs_term_q == (prev_q[11] && $past(rtt_div_q) != 4'h0)) else $error("tdqs wrong");
  a_rtt_off: assert property (off_cause |=> rtt_div_q == 4'h0)
    else $error("termination not off");
  a_rtt_dyn_write: assert property (dyn_cause |=> rtt_div_q == $past(rtt_wr_div))
    else $error("write termination wrong");
  a_reset_pulse: assert property (dll_reset_q |=> !dll_reset_q)
    else $error("dll reset pulse too long");
endmodule
bind dram_mode_register_one mode_reg_chk mode_reg_chk_i (.core_clk(core_clk),
  .reset_n(reset_n), .odt_pin(odt_pin), .self_refresh(self_refresh), .rd_burst(rd_burst),
  .wr_burst(wr_burst), .rtt_wr_div(rtt_wr_div), .ext_mode_q(ext_mode_q),
  .dll_on_q(dll_on_q), .dll_reset_q(dll_reset_q), .drive_div_q(drive_div_q),
  .rtt_div_q(rtt_div_q), .out_enable_q(out_enable_q), .tdqs_term_q(tdqs_term_q),
  .write_level_q(write_level_q), .add_lat_q(add_lat_q));

// ===== bench/mem_ctrl_model.sv
// Controller model: makes the free running memory clock and issues commands.
`timescale 1ns/1ps
module mem_ctrl_model (
  output logic mem_ck, // Memory clock.
  output mode_reg_pkg::cmd_pins_t cmd_pins, // Command pins.
  output logic [2:0] bank_addr, // Bank pins.
  output logic [16:0] addr // Address pins.
);
  realtime cmd_t;
  initial begin
    cmd_pins = 4'hF;
    bank_addr = 3'h7;
    addr = 17'h1FFFF;
    mem_ck = 1'b0;
    #13;
    forever #32 mem_ck = ~mem_ck;
  end
  // Idle bank and address pins show the inverse of the requested value, never a stale match; command pins go to all ones.
  task automatic issue(input mode_reg_pkg::cmd_pins_t c, input logic [2:0] ba,
                       input logic [16:0] a);
    @(posedge mem_ck);
    cmd_pins <= c;
    bank_addr <= ba;
    addr <= (ba == 3'h1) ? (a & ~mode_reg_pkg::EXT_RESERVED_MASK) : a;
    @(posedge mem_ck);
    cmd_t = $realtime;
    cmd_pins <= 4'hF;
    bank_addr <= ~ba;
    addr <= ~a;
    if (c == mode_reg_pkg::CMD_MODE_SET) repeat (6) @(posedge mem_ck);
    else @(posedge mem_ck);
  endtask
endmodule

// ===== bench/dram_mode_register_one_test.sv
// Self-checking bench of the extended mode register block.
`timescale 1ns/1ps
module dram_mode_register_one_test;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic mem_ck;
  mode_reg_pkg::cmd_pins_t cmd_pins;
  logic [2:0] bank_addr;
  logic [16:0] addr, ext_mode_q;
  logic odt_pin = 1'b0, self_refresh = 1'b0, rd_burst = 1'b0, wr_burst = 1'b0;
  logic [3:0] rtt_wr_div = 4'h0;
  logic dll_on_q, dll_reset_q, out_enable_q, dm_enable_q, tdqs_term_q, write_level_q;
  logic [3:0] drive_div_q, rtt_div_q, add_lat_q;
  logic [4:0] read_lat_q, write_lat_q;
  logic rd_release_q, wr_release_q;
  int fail_count = 0;
  int check_count = 0;
  int pulses = 0;
  realtime rel_t;
  dram_mode_register_one dram_mode_register_one_i (.*);
  mem_ctrl_model mem_ctrl_model_i (.*);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (dll_reset_q === 1'b1) pulses++;
  always @(posedge core_clk) if (rd_release_q === 1'b1 || wr_release_q === 1'b1) rel_t = $realtime;
  initial begin
    #300000;
    fail_count++;
    print_verdict;
  end
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic set_ext(input logic [16:0] w);
    mem_ctrl_model_i.issue(mode_reg_pkg::CMD_MODE_SET, 3'h1, w);
    tick(2);
  endtask
  // The memory side needs four of its own edges inside reset as well.
  task automatic do_reset;
    reset_n <= 1'b0;
    tick(20);
    repeat (4) @(posedge mem_ck);
    tick(1);
    reset_n <= 1'b1;
    repeat (4) @(posedge mem_ck);
    tick(2);
  endtask
  task automatic t_reset;
    check("ext", ext_mode_q, 17'h00000);
    check("drive", drive_div_q, 4'h6);
    check("dll", dll_on_q, 1'b1);
    check("oe", out_enable_q, 1'b1);
    check("dm", dm_enable_q, 1'b1);
    check("rl", read_lat_q, 5'h05);
    check("wl", write_lat_q, 5'h05);
    $display("test reset done");
  endtask
  task automatic t_fields;
    logic [16:0] w [10] = '{17'h00001, 17'h00002, 17'h00020, 17'h00022, 17'h01000,
                            17'h00800, 17'h00080, 17'h00008, 17'h00010, 17'h00018};
    logic [3:0] al;
    foreach (w[i]) begin
      set_ext(w[i]);
      al = (w[i][4:3] == 2'h1) ? 4'h4 : ((w[i][4:3] == 2'h2) ? 4'h3 : 4'h0);
      check("ext", ext_mode_q, w[i]);
      check("dll", dll_on_q, !w[i][0]);
      check("drive", drive_div_q, w[i][5] ? 4'h0 : (w[i][1] ? 4'h7 : 4'h6));
      check("oe", out_enable_q, !w[i][12]);
      check("dm", dm_enable_q, !w[i][11]);
      check("wlvl", write_level_q, w[i][7]);
      check("al", add_lat_q, al);
      check("rl", read_lat_q, 5'h05 + al);
    end
    $display("test fields done");
  endtask
  task automatic t_other;
    int p;
    set_ext(17'h00008);
    p = pulses;
    mem_ctrl_model_i.issue(mode_reg_pkg::CMD_MODE_SET, 3'h0, 17'h00120);
    mem_ctrl_model_i.issue(mode_reg_pkg::CMD_MODE_SET, 3'h0, 17'h00020);
    mem_ctrl_model_i.issue(mode_reg_pkg::CMD_MODE_SET, 3'h2, 17'h00008);
    tick(2);
    check("ext", ext_mode_q, 17'h00008);
    check("pulse", 17'(pulses - p), 17'h00001);
    check("al", add_lat_q, 4'h5);
    check("rl", read_lat_q, 5'h0B);
    check("wl", write_lat_q, 5'h0B);
    $display("test other registers done");
  endtask
  task automatic t_release(input logic [16:0] w, input int al);
    mode_reg_pkg::cmd_pins_t c;
    realtime d;
    set_ext(w);
    for (int k = 0; k < 2; k++) begin
      c = k ? mode_reg_pkg::CMD_WRITE : mode_reg_pkg::CMD_READ;
      rel_t = 0;
      mem_ctrl_model_i.issue(c, 3'h0, 17'h00000);
      tick(45);
      d = rel_t - mem_ctrl_model_i.cmd_t;
      check("release", d >= al * 64 + 20 && d <= al * 64 + 70, 1'b1);
    end
    $display("test release done");
  endtask
  task automatic t_rtt;
    logic [3:0] div [6] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hC, 4'h8};
    odt_pin <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      set_ext({7'h00, c[2], 2'h0, c[1], 3'h0, c[0], 2'h0});
      check("rtt", rtt_div_q, div[c]);
    end
    set_ext(17'h00804);
    check("tdqs", tdqs_term_q, 1'b1);
    rtt_wr_div <= 4'h2;
    wr_burst <= 1'b1;
    tick(2);
    check("rtt", rtt_div_q, 4'h2);
    wr_burst <= 1'b0;
    rd_burst <= 1'b1;
    tick(2);
    check("rtt", rtt_div_q, 4'h0);
    rd_burst <= 1'b0;
    tick(2);
    check("rtt", rtt_div_q, 4'h4);
    odt_pin <= 1'b0;
    tick(4);
    check("rtt", rtt_div_q, 4'h0);
    odt_pin <= 1'b1;
    set_ext(17'h00280);
    check("rtt", rtt_div_q, 4'h0);
    set_ext(17'h01280);
    check("rtt", rtt_div_q, 4'hC);
    $display("test termination done");
  endtask
  task automatic t_selfref;
    int p;
    for (int k = 0; k < 2; k++) begin
      set_ext({16'h0000, k[0]});
      p = pulses;
      self_refresh <= 1'b1;
      tick(3);
      check("dll", dll_on_q, 1'b0);
      self_refresh <= 1'b0;
      tick(3);
      check("dll", dll_on_q, !k[0]);
      check("pulse", 17'(pulses - p), 17'(1 - k));
    end
    $display("test self refresh done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    do_reset;
    t_reset;
    t_fields;
    t_other;
    t_release(17'h00000, 0);
    t_release(17'h00008, 5);
    t_release(17'h00010, 4);
    t_rtt;
    t_selfref;
    set_ext(17'h00022);
    do_reset;
    t_reset;
    print_verdict;
  end
endmodule
